// File: design/fsh_host.sv
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module fsh_host (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // apb slave
    input wire fsh_pkg::fsh_apb_req_t apbReq,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // flash pins
    output fsh_pkg::fsh_pins_t flashPins,
    input wire logic [15:0] flashDqIn,
    output logic resetPinN
);

    // tracks the read mode the device is in after each command
    function automatic logic nextMode(input logic [15:0] cmd,
                                      input logic cur);
        logic res;
        res = cur;
        unique case (cmd[7:0])
            fsh_pkg::CMD_CLEAR[7:0],
            fsh_pkg::CMD_RD_STATUS[7:0],
            fsh_pkg::CMD_PROG_W, fsh_pkg::CMD_PROG_B,
            fsh_pkg::CMD_PROG_BUF, fsh_pkg::CMD_ERASE,
            fsh_pkg::CMD_LOCK, fsh_pkg::CMD_RESUME: res = 1'b1;
            fsh_pkg::CMD_RD_ARRAY, fsh_pkg::CMD_RD_INFO,
            fsh_pkg::CMD_QUERY: res = 1'b0;
            default: res = cur;
        endcase
        return res;
    endfunction : nextMode

    fsh_pkg::fsh_state_t state_q, state_d;
    fsh_pkg::fsh_pins_t pins_q, pins_d;
    logic [3:0] cnt_q, cnt_d;
    logic [23:0] addr_q, addr_d;
    logic [15:0] wdata_q, wdata_d;
    logic [7:0] devStatus_q, devStatus_d;
    logic highBad_q, highBad_d;
    logic statusMode_q, statusMode_d;
    logic readPend_q, readPend_d;
    logic resetPin_q;
    logic [15:0] dqSync1_q, dqSync2_q;

    // apb decode
    wire logic apbSetup = apbReq.psel && !apbReq.penable;
    wire logic apbAccess = apbReq.psel && apbReq.penable;
    wire logic apbWrite = apbAccess && apbReq.pwrite;
    wire logic hitCmd = apbReq.paddr == fsh_pkg::OFS_CMD;
    wire logic hitAddr = apbReq.paddr == fsh_pkg::OFS_ADDR;
    wire logic hitWdata = apbReq.paddr == fsh_pkg::OFS_WDATA;
    wire logic hitStat = apbReq.paddr == fsh_pkg::OFS_STAT;
    wire logic hitAny = hitCmd || hitAddr || hitWdata || hitStat;
    wire logic idle = state_q == fsh_pkg::ST_IDLE;
    wire logic start = apbWrite && hitCmd && idle;
    wire fsh_pkg::fsh_op_t op = fsh_pkg::fsh_op_t'(
        apbReq.pwdata[fsh_pkg::CMD_OP_MSB:fsh_pkg::CMD_OP_LSB]);

    // command word chosen by the requested operation
    wire logic [15:0] opWord =
        (op == fsh_pkg::OP_CLEAR) ? fsh_pkg::CMD_CLEAR :
        (op == fsh_pkg::OP_STATUS) ? fsh_pkg::CMD_RD_STATUS :
        wdata_q;
    // a status poll skips the mode command when already in status mode
    wire logic opNeedsWrite = (op != fsh_pkg::OP_READ) &&
        !(op == fsh_pkg::OP_STATUS && statusMode_q);
    wire logic opNeedsRead = (op == fsh_pkg::OP_STATUS) ||
        (op == fsh_pkg::OP_READ);

    // while busy, bits 6:0 are not driven and are shown as zero
    wire logic [7:0] sampled = dqSync2_q[7:0];
    wire logic [7:0] statusView = sampled[fsh_pkg::BIT_READY] ?
        {sampled[7:1], 1'b0} :
        {1'b0, 7'h00};

    // apb answer: no wait states
    wire logic [31:0] statWord = {19'h00000, devStatus_q[5:4],
        highBad_q, statusMode_q, !idle, devStatus_q};
    assign pready = 1'b1;
    assign pslverr = apbAccess && !hitAny;
    assign prdata = !(apbAccess && !apbReq.pwrite) ? 32'h00000000 :
        hitCmd ? {30'h00000000, readPend_q, !idle} :
        hitAddr ? {8'h00, addr_q} :
        hitWdata ? {16'h0000, wdata_q} :
        hitStat ? statWord : 32'h00000000;

    assign flashPins = pins_q;
    assign resetPinN = resetPin_q;

    // registers software can write; address and data held while busy
    always_comb begin
        addr_d = addr_q;
        wdata_d = wdata_q;
        if (apbWrite && idle && hitAddr) begin
            addr_d = apbReq.pwdata[23:0];
        end
        if (apbWrite && idle && hitWdata) begin
            wdata_d = apbReq.pwdata[15:0];
        end
    end

    // pin sequencer
    always_comb begin
        state_d = state_q;
        pins_d = pins_q;
        cnt_d = cnt_q;
        devStatus_d = devStatus_q;
        highBad_d = highBad_q;
        statusMode_d = statusMode_q;
        readPend_d = readPend_q;
        pins_d.addr = addr_q;
        unique case (state_q)
            fsh_pkg::ST_IDLE: begin
                pins_d.chipSelectN = 1'b1;
                pins_d.outEnableN = 1'b1;
                pins_d.writeEnableN = 1'b1;
                pins_d.dqOe = 1'b0;
                if (start && opNeedsWrite) begin
                    // bus write cycle carries the command
                    state_d = fsh_pkg::ST_WLOW;
                    cnt_d = fsh_pkg::WR_LOW_CYC;
                    pins_d.chipSelectN = 1'b0;
                    pins_d.writeEnableN = 1'b0;
                    pins_d.dqOe = 1'b1;
                    pins_d.dqOut = opWord;
                    readPend_d = opNeedsRead;
                    statusMode_d = nextMode(opWord, statusMode_q);
                end else if (start) begin
                    state_d = fsh_pkg::ST_RLOW;
                    cnt_d = fsh_pkg::RD_LOW_CYC;
                    pins_d.chipSelectN = 1'b0;
                    pins_d.outEnableN = 1'b0;
                    readPend_d = 1'b0;
                end
            end
            fsh_pkg::ST_WLOW: begin
                cnt_d = cnt_q - 4'h1;
                if (cnt_q == 4'h1) begin
                    // rising write enable latches the command
                    state_d = fsh_pkg::ST_WHIGH;
                    cnt_d = fsh_pkg::WR_HIGH_CYC;
                    pins_d.writeEnableN = 1'b1;
                end
            end
            fsh_pkg::ST_WHIGH: begin
                cnt_d = cnt_q - 4'h1;
                pins_d.chipSelectN = 1'b1;
                if (cnt_q == 4'h1) begin
                    pins_d.dqOe = 1'b0;
                    if (readPend_q) begin
                        state_d = fsh_pkg::ST_RLOW;
                        cnt_d = fsh_pkg::RD_LOW_CYC;
                        pins_d.chipSelectN = 1'b0;
                        pins_d.outEnableN = 1'b0;
                        readPend_d = 1'b0;
                    end else begin
                        state_d = fsh_pkg::ST_IDLE;
                    end
                end
            end
            fsh_pkg::ST_RLOW: begin
                cnt_d = cnt_q - 4'h1;
                if (cnt_q == 4'h1) begin
                    // one word per select, no page bursts
                    devStatus_d = statusView;
                    highBad_d = dqSync2_q[15:8] != 8'h00;
                    state_d = fsh_pkg::ST_RHIGH;
                    cnt_d = fsh_pkg::RD_HIGH_CYC;
                    pins_d.outEnableN = 1'b1;
                    pins_d.chipSelectN = 1'b1;
                end
            end
            fsh_pkg::ST_RHIGH: begin
                cnt_d = cnt_q - 4'h1;
                if (cnt_q == 4'h1) begin
                    state_d = fsh_pkg::ST_IDLE;
                end
            end
            default: begin
                state_d = fsh_pkg::ST_IDLE;
            end
        endcase
    end

    // data lines come from another timing domain
    always_ff @(posedge mclk) begin
        dqSync1_q <= flashDqIn;
        dqSync2_q <= dqSync1_q;
    end

    // device reset pin follows system reset; device then in array mode
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            resetPin_q <= 1'b0;
            statusMode_q <= 1'b0;
            devStatus_q <= fsh_pkg::DEV_STATUS_RST;
            highBad_q <= 1'b0;
        end else begin
            resetPin_q <= 1'b1;
            statusMode_q <= statusMode_d;
            devStatus_q <= devStatus_d;
            highBad_q <= highBad_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            state_q <= fsh_pkg::ST_IDLE;
            cnt_q <= 4'h0;
            readPend_q <= 1'b0;
            addr_q <= fsh_pkg::ADDR_RST;
            wdata_q <= fsh_pkg::WDATA_RST;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            readPend_q <= readPend_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            pins_q <= '{chipSelectN: 1'b1, outEnableN: 1'b1,
                        writeEnableN: 1'b1, dqOe: 1'b0,
                        addr: fsh_pkg::ADDR_RST, dqOut: 16'h0000};
        end else begin
            pins_q <= pins_d;
        end
    end

    // apbSetup is decoded for completeness of the bus phases
    wire logic unusedSetup = apbSetup;

endmodule : fsh_host

`default_nettype wire

// File: design/fsh_pkg.sv
package fsh_pkg;

    // software-visible register offsets (byte addresses, one word each)
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_ADDR = 8'h04;
    localparam logic [7:0] OFS_WDATA = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0c;

    // command register fields
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_OP_MSB = 1;

    // status register fields
    localparam int STAT_BYTE_LSB = 0;
    localparam int STAT_BUSY = 8;
    localparam int STAT_MODE = 9;
    localparam int STAT_HIGH_BAD = 10;
    localparam int STAT_ERR = 11;

    // reset values
    localparam logic [23:0] ADDR_RST = 24'h000000;
    localparam logic [15:0] WDATA_RST = 16'h0000;
    localparam logic [7:0] DEV_STATUS_RST = 8'h80;

    // device command codes
    localparam logic [15:0] CMD_CLEAR = 16'h0050;
    localparam logic [15:0] CMD_RD_STATUS = 16'h0070;
    localparam logic [7:0] CMD_RD_ARRAY = 8'hff;
    localparam logic [7:0] CMD_RD_INFO = 8'h90;
    localparam logic [7:0] CMD_QUERY = 8'h98;
    localparam logic [7:0] CMD_PROG_W = 8'h40;
    localparam logic [7:0] CMD_PROG_B = 8'h10;
    localparam logic [7:0] CMD_PROG_BUF = 8'he8;
    localparam logic [7:0] CMD_ERASE = 8'h20;
    localparam logic [7:0] CMD_LOCK = 8'h60;
    localparam logic [7:0] CMD_RESUME = 8'hd0;

    // device status bit positions
    localparam int BIT_READY = 7;
    localparam int BIT_ERASE_SUSP = 6;
    localparam int BIT_ERASE_FAIL = 5;
    localparam int BIT_PROG_FAIL = 4;
    localparam int BIT_SUPPLY = 3;
    localparam int BIT_PROG_SUSP = 2;
    localparam int BIT_LOCKED = 1;

    // pin timing, in ns and in 25 ns clock cycles
    localparam int CLK_NS = 25;
    localparam int T_WRITE_LOW_NS = 70;
    localparam int T_WRITE_HIGH_NS = 30;
    localparam int T_ACCESS_NS = 95;
    localparam int T_OE_HIGH_NS = 25;
    localparam int SYNC_CYC = 2;
    localparam logic [3:0] WR_LOW_CYC = 4'((T_WRITE_LOW_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] WR_HIGH_CYC = 4'((T_WRITE_HIGH_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] RD_LOW_CYC =
        4'((T_ACCESS_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC);
    localparam logic [3:0] RD_HIGH_CYC = 4'((T_OE_HIGH_NS + CLK_NS - 1) / CLK_NS);

    typedef enum logic [1:0] {
        OP_CLEAR = 2'b00,
        OP_STATUS = 2'b01,
        OP_RAW = 2'b10,
        OP_READ = 2'b11
    } fsh_op_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_WLOW = 3'b001,
        ST_WHIGH = 3'b010,
        ST_RLOW = 3'b011,
        ST_RHIGH = 3'b100
    } fsh_state_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } fsh_apb_req_t;

    typedef struct packed {
        logic chipSelectN;
        logic outEnableN;
        logic writeEnableN;
        logic dqOe;
        logic [23:0] addr;
        logic [15:0] dqOut;
    } fsh_pins_t;

endpackage : fsh_pkg

// File: bench/fsh_host_props.sv
`timescale 1ns/10ps
`default_nettype none

module fsh_host_props (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // apb side
    input wire fsh_pkg::fsh_apb_req_t apbReq,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    // flash side
    input wire fsh_pkg::fsh_pins_t flashPins,
    input wire logic resetPinN
);
    wire logic access = apbReq.psel && apbReq.penable;
    wire logic statRd = access && !apbReq.pwrite
        && apbReq.paddr == fsh_pkg::OFS_STAT;
    wire logic mapped = apbReq.paddr inside {fsh_pkg::OFS_CMD,
        fsh_pkg::OFS_ADDR, fsh_pkg::OFS_WDATA, fsh_pkg::OFS_STAT};

    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);

    a_no_wait: assert property (pready)
        else $error("pready dropped");
    a_unmapped_err: assert property (access && !mapped |-> pslverr
        && prdata == 32'h0) else $error("unmapped access not refused");
    a_write_pulse: assert property ($fell(flashPins.writeEnableN) |->
        !flashPins.writeEnableN [*3] ##1 flashPins.writeEnableN)
        else $error("write strobe width wrong");
    a_write_framed: assert property (!flashPins.writeEnableN |->
        !flashPins.chipSelectN && flashPins.dqOe)
        else $error("write strobe without select or data");
    a_no_contention: assert property (!flashPins.outEnableN |->
        !flashPins.dqOe && !flashPins.chipSelectN)
        else $error("read while host drives data");
    a_read_window: assert property ($fell(flashPins.outEnableN) |->
        !flashPins.outEnableN [*6] ##1
        (flashPins.outEnableN && flashPins.chipSelectN))
        else $error("read window or release wrong");
    a_busy_bits: assert property (statRd && !prdata[7] |->
        prdata[6:0] == 7'h00) else $error("busy status shows bits");
    a_bit0_zero: assert property (statRd |-> !prdata[0])
        else $error("status bit 0 set");
    a_err_copy: assert property (statRd |->
        prdata[12:11] == prdata[5:4]) else $error("outcome copy wrong");
    a_reset_pin: assert property (rstn && $past(rstn) |-> resetPinN)
        else $error("device reset pin low");
endmodule : fsh_host_props

bind fsh_host fsh_host_props chk (.mclk(mclk), .rstn(rstn),
    .apbReq(apbReq), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .flashPins(flashPins), .resetPinN(resetPinN));

`default_nettype wire

// File: bench/fsh_flash_model.sv
`timescale 1ns/10ps
`default_nettype none

module fsh_flash_model (
    // pins from the host
    input wire fsh_pkg::fsh_pins_t pins,
    input wire logic resetPinN,
    // device-internal events
    input wire logic injLoad,
    input wire logic [7:0] injVal,
    // observation
    output logic [15:0] dqOut,
    output logic [15:0] lastCmd
);
    logic [7:0] statusQ;
    logic [7:0] latchQ;
    logic modeQ;
    wire logic sel = !pins.chipSelectN && !pins.outEnableN && resetPinN;
    wire logic [7:0] lowByte = latchQ[7] ? latchQ : {1'b0, ~latchQ[6:0]};

    // released lines show the inverse of the last latched status byte, with the upper byte high
    assign dqOut = !sel ? ~{8'h00, latchQ} :
        modeQ ? {8'h00, lowByte} : 16'hc3a5;

    always @(negedge resetPinN) begin
        statusQ = 8'h80;
        latchQ = 8'h80;
        modeQ = 1'b0;
        lastCmd = 16'h0000;
    end
    always @(posedge injLoad) statusQ = {injVal[7:1], 1'b0};
    always @(negedge pins.outEnableN or negedge pins.chipSelectN) begin
        // decode the pins directly: the sel net may not have settled yet
        if (!pins.chipSelectN && !pins.outEnableN && resetPinN === 1'b1)
            latchQ = statusQ;
    end
    always @(posedge pins.writeEnableN) begin
        if (resetPinN === 1'b1 && !pins.chipSelectN) begin
            lastCmd = pins.dqOut;
            if (pins.dqOut == 16'h0050)
                statusQ = statusQ & 8'hc5;
            if (pins.dqOut[7:0] inside {8'h50, 8'h70, 8'h40, 8'h10,
                8'he8, 8'h20, 8'h60, 8'hd0})
                modeQ = 1'b1;
            else if (pins.dqOut[7:0] inside {8'hff, 8'h90, 8'h98})
                modeQ = 1'b0;
        end
    end
endmodule : fsh_flash_model

`default_nettype wire

// File: bench/testbench.sv
`timescale 1ns/10ps
`default_nettype none

module testbench;
    logic mclk;
    logic rstn;
    fsh_pkg::fsh_apb_req_t req;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    fsh_pkg::fsh_pins_t pins;
    logic resetPinN;
    logic [15:0] devDq;
    logic [15:0] lastCmd;
    logic injLoad;
    logic [7:0] injVal;
    logic [31:0] r;
    logic e;
    int errCount;
    int checksDone;
    int cycles;
    wire logic [15:0] dqWire = pins.dqOe ? pins.dqOut : devDq;

    fsh_host dut (.mclk(mclk), .rstn(rstn), .apbReq(req), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .flashPins(pins),
        .flashDqIn(dqWire), .resetPinN(resetPinN));
    fsh_flash_model dev (.pins(pins), .resetPinN(resetPinN),
        .injLoad(injLoad), .injVal(injVal), .dqOut(devDq),
        .lastCmd(lastCmd));

    task automatic finish_test;
        if (errCount == 0 && checksDone > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : finish_test

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            errCount++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge mclk);
        req <= '{1'b1, 1'b0, wr, a, d};
        @(posedge mclk);
        req.penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        r = prdata;
        e = pslverr;
        req <= '0;
    endtask : apb

    // start an operation and poll until the host is idle again
    task automatic run_op(input logic [1:0] op);
        apb(1'b1, fsh_pkg::OFS_CMD, {30'h0, op});
        r = 32'h100;
        for (int i = 0; i < 60 && r[8] !== 1'b0; i++)
            apb(1'b0, fsh_pkg::OFS_STAT, 32'h0);
    endtask : run_op

    task automatic inject(input logic [7:0] v);
        @(posedge mclk);
        injVal <= v;
        injLoad <= 1'b1;
        @(posedge mclk);
        injLoad <= 1'b0;
    endtask : inject

    task automatic t_reset;
        apb(1'b0, fsh_pkg::OFS_STAT, 32'h0);
        check(r, 32'h80);
        check(resetPinN, 1'b1);
    endtask : t_reset

    task automatic t_status;
        inject(8'hd6);
        run_op(2'd1);
        check(r[7:0], 8'hd6);
        check(r[12:8], 5'b01010);
        check(lastCmd, fsh_pkg::CMD_RD_STATUS);
    endtask : t_status

    task automatic t_seq_err;
        inject(8'hf9);
        run_op(2'd1);
        check(r[7:0], 8'hf8);
        check(r[12:11], 2'b11);
        run_op(2'd1);
        check(r[7:0], 8'hf8);
    endtask : t_seq_err

    task automatic t_clear;
        apb(1'b1, fsh_pkg::OFS_ADDR, 32'h0080_0000);
        apb(1'b0, fsh_pkg::OFS_ADDR, 32'h0);
        check(r, 32'h0080_0000);
        run_op(2'd0);
        check(pins.addr, 24'h800000);
        check(lastCmd, fsh_pkg::CMD_CLEAR);
        run_op(2'd1);
        check(r[9:0], 10'h2c0);
    endtask : t_clear

    task automatic t_busy;
        inject(8'h00);
        run_op(2'd1);
        check(r[7:0], 8'h00);
    endtask : t_busy

    task automatic t_mode;
        apb(1'b1, fsh_pkg::OFS_WDATA, 32'h0000_00ff);
        run_op(2'd2);
        check(lastCmd, 16'h00ff);
        check(r[9], 1'b0);
        inject(8'h80);
        run_op(2'd1);
        check(lastCmd, fsh_pkg::CMD_RD_STATUS);
        check(r[9:0], 10'h280);
    endtask : t_mode

    task automatic t_bus;
        apb(1'b1, fsh_pkg::OFS_STAT, 32'hffff_ffff);
        apb(1'b0, fsh_pkg::OFS_STAT, 32'h0);
        check(r, 32'h280);
        apb(1'b0, 8'h10, 32'h0);
        check(e, 1'b1);
        check(r, 32'h0);
    endtask : t_bus

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            errCount++;
            finish_test;
        end
    end

    initial begin
        req = '0;
        rstn = 1'b0;
        injLoad = 1'b0;
        injVal = 8'h80;
        errCount = 0;
        checksDone = 0;
        cycles = 0;
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        t_reset;
        t_status;
        t_seq_err;
        t_clear;
        t_busy;
        t_mode;
        t_bus;
        finish_test;
    end
endmodule : testbench

`default_nettype wire
